// ==== logic/lpsr_regs.svh ====
// Purpose: Timing counts for the pseudo-static memory host controller
// Assumes: 20 MHz clock, fastest speed grade figures
// Notes: Times in ns, cycle counts derived by rounding up minimums
`ifndef LPSR_REGS_SVH
`define LPSR_REGS_SVH
`define LPSR_CLK_NS 50
`define LPSR_CYC(ns) (((ns) + `LPSR_CLK_NS - 1) / `LPSR_CLK_NS)
`define LPSR_T_CE_NS 120
`define LPSR_T_P_NS 90
`define LPSR_T_CEA_NS 120
`define LPSR_T_OEL_NS 170
`define LPSR_T_RC_NS 280
`define LPSR_T_RDP_NS 50
`define LPSR_T_RP_NS 90
`define LPSR_T_AHC_NS 35
`define LPSR_T_WD_NS 60
`define LPSR_T_RDS_NS 40000
`define LPSR_T_RSR_NS 2000
`define LPSR_T_PWRUP_NS 2000000
`define LPSR_N_CE_DUMMY 8
`define LPSR_N_RF_DUMMY 64
`define LPSR_ROW_BITS 7
`endif

// ==== logic/lpsr_pkg.sv ====
// Purpose: Types for the pseudo-static memory host controller
// Assumes: Nothing
// Notes: Host request and reply carriers
`default_nettype none
package lpsr_pkg;
	typedef enum logic [2:0] {
		LPSR_OP_READ,
		LPSR_OP_EARLY_WRITE,
		LPSR_OP_LATE_WRITE,
		LPSR_OP_EXT_REFRESH,
		LPSR_OP_PULSE_REFRESH,
		LPSR_OP_SELF_REFRESH,
		LPSR_OP_DESELECT
	} lpsr_op_t;
	typedef struct packed {
		lpsr_op_t op;
		logic [12:0] addr;
		logic [7:0] wdata;
		logic [31:0] hold_cycles;
	} lpsr_req_t;
	typedef struct packed {
		logic done;
		logic rvalid;
		logic [7:0] rdata;
	} lpsr_rsp_t;
endpackage
`default_nettype wire

// ==== logic/lpsr_sync.sv ====
// Purpose: Three-stage input synchroniser for the data pins
// Assumes: Inputs come from another domain
// Notes: A change is taken once stages two and three agree
`default_nettype none
module lpsr_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	always_ff @(posedge clk) begin
		if (srst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (srst)
					dout[i] <= 1'b0;
				else if (s2[i] == s3[i])
					dout[i] <= s3[i];
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== logic/lpsr_host.sv ====
// Purpose: Host controller driving an edge-latched 8K x 8 pseudo-static memory
// Assumes: 20 MHz clk, one request at a time, fastest speed grade
// Notes: Runs power-up init itself, then accepts read, write and refresh requests
// Notes on behaviour
// - Write-enable timing against chip enable picks early or late write.
// - Cycle type decodes from write and output enables with refresh high.
// - Host keeps refresh input high during normal reads and writes.
// - Host waits 2 us after leaving self refresh before any cycle.
// - After power-up wait 2 ms, then 8 enable and 64 refresh dummies.
// - Refresh dummies may precede or follow enable dummies; any cycle counts.
// - Enable activity ends 170 ns before a following pulse refresh.
// - Host waits 280 ns after a refresh strobe before chip-enable fall.
`include "lpsr_regs.svh"
`default_nettype none
module lpsr_host #(
	parameter int PWRUP_CYC = `LPSR_CYC(`LPSR_T_PWRUP_NS),
	parameter int SELF_CYC = `LPSR_CYC(`LPSR_T_RDS_NS)
) (
	input wire logic clk,
	input wire logic srst,
	input wire lpsr_pkg::lpsr_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output lpsr_pkg::lpsr_rsp_t rsp,
	output logic chip_enable_n,
	output logic chip_select,
	output logic write_enable_n,
	output logic output_enable_n,
	output logic refresh_strobe,
	output logic [12:0] word_addr,
	output logic [7:0] data_pins_out,
	output logic data_pins_oe,
	input wire logic [7:0] data_pins_in
);
	localparam int CE_CYC = `LPSR_CYC(`LPSR_T_CE_NS);
	localparam int P_CYC = `LPSR_CYC(`LPSR_T_P_NS);
	localparam int OEL_CYC = `LPSR_CYC(`LPSR_T_OEL_NS);
	localparam int RC_CYC = `LPSR_CYC(`LPSR_T_RC_NS);
	localparam int RDP_CYC = `LPSR_CYC(`LPSR_T_RDP_NS);
	localparam int RP_CYC = `LPSR_CYC(`LPSR_T_RP_NS);
	localparam int WD_CYC = `LPSR_CYC(`LPSR_T_WD_NS);
	localparam int RSR_CYC = `LPSR_CYC(`LPSR_T_RSR_NS);
	// Read sample waits access plus four cycles of synchroniser delay (three stages and the output register)
	localparam int RD_CYC = `LPSR_CYC(`LPSR_T_CEA_NS) + 4;

	typedef enum logic [3:0] {
		S_PWRUP, S_INIT, S_IDLE, S_CE_LOW, S_LATE_WE, S_CE_HIGH,
		S_RF_LOW, S_RF_HIGH, S_SELF, S_SELF_EXIT, S_DONE
	} lpsr_state_t;

	lpsr_state_t state;
	lpsr_pkg::lpsr_req_t cur;
	logic [31:0] cnt;
	logic [31:0] hold;
	logic [3:0] ce_dummies;
	logic [6:0] rf_dummies;
	logic init_done;
	logic last_was_ce;
	logic [7:0] rd_sync;

	lpsr_sync #(.WIDTH(8)) u_sync (
		.clk(clk),
		.srst(srst),
		.din(data_pins_in),
		.dout(rd_sync)
	);

	wire logic is_write = (cur.op == lpsr_pkg::LPSR_OP_EARLY_WRITE) ||
		(cur.op == lpsr_pkg::LPSR_OP_LATE_WRITE);
	wire logic ce_min_met = cnt >= 32'(CE_CYC) && cnt >= hold;
	// A pulse right after an enable cycle waits out the enable lead time first
	wire logic [31:0] rf_lead = last_was_ce ? 32'(OEL_CYC - P_CYC) : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= S_PWRUP;
			cnt <= '0;
			hold <= '0;
			cur <= '0;
			ce_dummies <= '0;
			rf_dummies <= '0;
			init_done <= 1'b0;
			last_was_ce <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			cnt <= cnt + 32'd1;
			case (state)
			S_PWRUP: begin
				if (cnt >= 32'(PWRUP_CYC)) begin
					state <= S_INIT;
					cnt <= '0;
				end
			end
			S_INIT: begin
				// Refresh dummies first, then enable dummies as deselected cycles
				cnt <= '0;
				hold <= '0;
				if (rf_dummies < 7'(`LPSR_N_RF_DUMMY)) begin
					cur.op <= lpsr_pkg::LPSR_OP_PULSE_REFRESH;
					state <= S_RF_LOW;
				end else if (ce_dummies < 4'(`LPSR_N_CE_DUMMY)) begin
					cur.op <= lpsr_pkg::LPSR_OP_DESELECT;
					cur.addr <= '0;
					state <= S_CE_LOW;
				end else begin
					init_done <= 1'b1;
					req_ready <= 1'b1;
					state <= S_IDLE;
				end
			end
			S_IDLE: begin
				cnt <= '0;
				if (req_valid) begin
					req_ready <= 1'b0;
					cur <= req;
					hold <= req.hold_cycles;
					case (req.op)
					lpsr_pkg::LPSR_OP_PULSE_REFRESH,
					lpsr_pkg::LPSR_OP_SELF_REFRESH: state <= S_RF_LOW;
					default: state <= S_CE_LOW;
					endcase
				end
			end
			S_CE_LOW: begin
				if (cur.op == lpsr_pkg::LPSR_OP_LATE_WRITE && cnt == 32'(WD_CYC)) begin
					state <= S_LATE_WE;
				end else if (ce_min_met && cnt >= 32'(RD_CYC)) begin
					state <= S_CE_HIGH;
					cnt <= '0;
				end
			end
			S_LATE_WE: begin
				if (ce_min_met && cnt >= 32'(RD_CYC)) begin
					state <= S_CE_HIGH;
					cnt <= '0;
				end
			end
			S_CE_HIGH: begin
				// Precharge done by the device; we only wait it out
				if (cnt + 32'd1 >= 32'(P_CYC)) begin
					last_was_ce <= 1'b1;
					cnt <= '0;
					state <= init_done ? S_DONE : S_INIT;
					if (!init_done)
						ce_dummies <= ce_dummies + 4'd1;
				end
			end
			S_RF_LOW: begin
				// A pulse after an enable cycle waits the enable lead time
				if (cur.op == lpsr_pkg::LPSR_OP_SELF_REFRESH) begin
					if (cnt >= 32'(SELF_CYC) && cnt >= hold) begin
						state <= S_SELF_EXIT;
						cnt <= '0;
					end
				end else if (cnt >= 32'(RDP_CYC) + rf_lead) begin
					state <= S_RF_HIGH;
					cnt <= '0;
				end
			end
			S_RF_HIGH: begin
				if (cnt + 32'd1 >= 32'(RC_CYC > RP_CYC ? RC_CYC : RP_CYC)) begin
					last_was_ce <= 1'b0;
					cnt <= '0;
					if (!init_done)
						rf_dummies <= rf_dummies + 7'd1;
					state <= init_done ? S_DONE : S_INIT;
				end
			end
			S_SELF_EXIT: begin
				if (cnt + 32'd1 >= 32'(RSR_CYC)) begin
					state <= S_DONE;
					last_was_ce <= 1'b0;
				end
			end
			S_DONE: begin
				req_ready <= 1'b1;
				state <= S_IDLE;
			end
			default: state <= S_PWRUP;
			endcase
		end
	end

	// Pin drive; all outputs registered from the current state view
	always_ff @(posedge clk) begin
		if (srst) begin
			chip_enable_n <= 1'b1;
			chip_select <= 1'b0;
			write_enable_n <= 1'b1;
			output_enable_n <= 1'b1;
			refresh_strobe <= 1'b1;
			word_addr <= '0;
			data_pins_out <= '0;
			data_pins_oe <= 1'b0;
		end else begin
			refresh_strobe <= !((state == S_RF_LOW) &&
				!(cur.op == lpsr_pkg::LPSR_OP_PULSE_REFRESH && cnt < rf_lead));
			chip_enable_n <= !(state == S_CE_LOW || state == S_LATE_WE);
			if (state == S_IDLE || state == S_INIT) begin
				word_addr <= (state == S_IDLE) ? req.addr : 13'h0000;
				chip_select <= (state == S_IDLE) && req_valid &&
					req.op != lpsr_pkg::LPSR_OP_DESELECT;
				write_enable_n <= !(state == S_IDLE && req_valid &&
					req.op == lpsr_pkg::LPSR_OP_EARLY_WRITE);
				data_pins_out <= req.wdata;
				data_pins_oe <= (state == S_IDLE) && req_valid &&
					req.op == lpsr_pkg::LPSR_OP_EARLY_WRITE;
				output_enable_n <= !(state == S_IDLE && req_valid &&
					req.op == lpsr_pkg::LPSR_OP_READ);
			end else if (state == S_CE_LOW && cur.op == lpsr_pkg::LPSR_OP_LATE_WRITE &&
				cnt == 32'(WD_CYC)) begin
				write_enable_n <= 1'b0;
				data_pins_oe <= 1'b1;
			end else if (state == S_CE_HIGH) begin
				write_enable_n <= 1'b1;
				output_enable_n <= 1'b1;
				data_pins_oe <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			rsp <= '0;
		else begin
			rsp.done <= (state == S_DONE);
			rsp.rvalid <= 1'b0;
			if (state == S_CE_LOW && cur.op == lpsr_pkg::LPSR_OP_READ && chip_select &&
				ce_min_met && cnt >= 32'(RD_CYC)) begin
				rsp.rvalid <= 1'b1;
				rsp.rdata <= rd_sync;
			end
		end
	end

	a_refresh_high_ce: assert property (@(posedge clk) disable iff (srst)
		!chip_enable_n |-> refresh_strobe)
		else $error("refresh strobe low during enable cycle");
	a_float_when_deselect: assert property (@(posedge clk) disable iff (srst)
		!chip_enable_n && !chip_select |-> !data_pins_oe)
		else $error("data driven while deselected");
	a_oe_we_excl: assert property (@(posedge clk) disable iff (srst)
		!output_enable_n |-> !data_pins_oe && write_enable_n)
		else $error("read and write overlap");
	a_ce_precharge: assert property (@(posedge clk) disable iff (srst)
		$rose(chip_enable_n) |-> chip_enable_n [*2])
		else $error("precharge too short");
	a_ce_width: assert property (@(posedge clk) disable iff (srst)
		$fell(chip_enable_n) |-> !chip_enable_n [*3])
		else $error("enable pulse too short");
	a_rf_to_ce: assert property (@(posedge clk) disable iff (srst)
		$rose(refresh_strobe) |-> chip_enable_n [*6])
		else $error("enable too soon after refresh");
	a_addr_stable: assert property (@(posedge clk) disable iff (srst)
		!chip_enable_n && !$past(chip_enable_n) |-> $stable(word_addr))
		else $error("address moved in cycle");
	a_init_ready: assert property (@(posedge clk) disable iff (srst)
		req_ready |-> init_done)
		else $error("ready before init");
	a_drive_on_write: assert property (@(posedge clk) disable iff (srst)
		data_pins_oe |-> is_write && chip_select)
		else $error("data driven outside a write");
	c_read: cover property (@(posedge clk) rsp.rvalid);
	c_late: cover property (@(posedge clk) state == S_LATE_WE);
	c_self: cover property (@(posedge clk) state == S_SELF_EXIT);
endmodule
`default_nettype wire

// ==== verification/lpsr_dev_model.sv ====
// Purpose: Behavioural model of the latched pseudo-static memory
// Assumes: Host pins are registered and steady for a clock period
// Notes: Host rule breaks are counted in n_viol, not stopped on
`default_nettype none
module lpsr_dev_model #(
	parameter real SELF_NS = 500.0
) (
	input wire logic chip_enable_n,
	input wire logic chip_select,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	input wire logic refresh_strobe,
	input wire logic [12:0] word_addr,
	input wire logic [7:0] data_wire,
	output logic [7:0] dev_data,
	output logic dev_oe,
	output int n_ce = 0,
	output int n_rf = 0,
	output int n_viol = 0,
	output logic [6:0] row = 7'h00,
	output realtime self_ns = 0.0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:8191];
	logic [12:0] a = 13'h0000;
	logic cs_l = 1'b0;
	logic rd = 1'b0;
	logic early = 1'b0;
	realtime t_dn = 0.0;
	realtime t_up = -1.0e6;
	realtime t_ceup = -1.0e6;
	realtime t_act = -1.0e6;
	always @(posedge chip_enable_n) t_ceup = $realtime;
	// Last end of output or write enable activity, for the refresh lead time
	always @(posedge output_enable_n or posedge write_enable_n) t_act = $realtime;
	// Pins launched on the same clock edge settle in any order, so look 1 ns later
	always @(negedge chip_enable_n) begin
		n_ce++;
		if (refresh_strobe !== 1'b1) n_viol++;
		if ($realtime - t_up < ((self_ns >= SELF_NS) ? 2000.0 : 280.0)) n_viol++;
		if ($realtime - t_ceup < 90.0) n_viol++;
		#1;
		a = word_addr;
		cs_l = chip_select;
		early = !write_enable_n;
		rd = write_enable_n;
		if (cs_l && early) begin
			mem[a] = data_wire;
		end
	end
	always @(negedge write_enable_n) begin
		#2;
		if (!chip_enable_n && cs_l && !early) begin
			mem[a] = data_wire;
			rd = 1'b0;
		end
	end
	assign dev_oe = !chip_enable_n && cs_l && rd && !output_enable_n;
	assign dev_data = mem[a];
	always @(negedge refresh_strobe) begin
		t_dn = $realtime;
		if ($realtime - t_act < 170.0) n_viol++;
		if (chip_enable_n) begin
			n_rf++;
			row = row + 7'h01;
		end
	end
	always @(posedge refresh_strobe) begin
		t_up = $realtime;
		self_ns = $realtime - t_dn;
	end
endmodule
`default_nettype wire

// ==== verification/lpsr_host_tb_top.sv ====
// Purpose: Self-checking bench for the pseudo-static memory host
// Assumes: Shortened power-up and self refresh counts
// Notes: Expected memory is an associative array in the bench
`default_nettype none
module lpsr_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SELF = 10;
	logic clk = 1'b0;
	logic srst = 1'b1;
	lpsr_pkg::lpsr_req_t req = '0;
	logic req_valid = 1'b0;
	logic req_ready, ce_n, cs, we_n, oe_n, rf, host_oe, dev_oe;
	lpsr_pkg::lpsr_rsp_t rsp;
	logic [12:0] addr;
	logic [7:0] host_d, dev_d, pins, rdat, wd;
	logic [7:0] last = 8'h00;
	logic [6:0] base;
	logic [6:0] row_w;
	int n_ce, n_rf, n_viol, i, nce0;
	int num_errors = 0;
	int checked = 0;
	int seed = 32'ha2a2db2b;
	int exp_mem[int];
	logic [12:0] aa[16];
	realtime self_ns;
	always #25 clk = ~clk;
	// A released line shows the inverse of its last value so stale data cannot match
	assign pins = host_oe ? host_d : (dev_oe ? dev_d : ~last);
	always @(posedge clk) begin
		if (host_oe || dev_oe) last <= pins;
		if (host_oe && dev_oe) begin
			num_errors++;
			$display("mismatch at %0t: both drive data", $time);
		end
	end
	lpsr_host #(.PWRUP_CYC(20), .SELF_CYC(SELF)) u_dut (.clk(clk), .srst(srst), .req(req),
		.req_valid(req_valid), .req_ready(req_ready), .rsp(rsp), .chip_enable_n(ce_n),
		.chip_select(cs), .write_enable_n(we_n), .output_enable_n(oe_n), .refresh_strobe(rf),
		.word_addr(addr), .data_pins_out(host_d), .data_pins_oe(host_oe), .data_pins_in(pins));
	lpsr_dev_model #(.SELF_NS(SELF * 50.0)) u_dev (.chip_enable_n(ce_n), .chip_select(cs),
		.write_enable_n(we_n), .output_enable_n(oe_n), .refresh_strobe(rf), .word_addr(addr),
		.data_wire(pins), .dev_data(dev_d), .dev_oe(dev_oe), .n_ce(n_ce), .n_rf(n_rf),
		.n_viol(n_viol), .row(row_w), .self_ns(self_ns));
	task automatic give_verdict();
		$display("checked %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %0h want %0h", $time, m, got, exp);
		end
	endtask
	task automatic run(input lpsr_pkg::lpsr_op_t op, input logic [12:0] ad, input logic [7:0] d,
		input logic [31:0] hold = 32'h0000_0000);
		int j;
		@(negedge clk);
		// Ready is looked at on falling edges, away from the edge that changes it
		for (j = 0; j < 200 && req_ready !== 1'b1; j++) @(negedge clk);
		if (j == 200) begin
			num_errors++;
			$display("mismatch at %0t: ready timeout", $time);
			give_verdict();
		end
		req = '{op, ad, d, hold};
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		rdat = 8'hxx;
		for (j = 0; j < 5000; j++) begin
			@(negedge clk);
			if (rsp.rvalid === 1'b1) rdat = rsp.rdata;
			if (rsp.done === 1'b1) break;
		end
		if (j == 5000) begin
			num_errors++;
			$display("mismatch at %0t: done timeout", $time);
			give_verdict();
		end
	endtask
	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		for (i = 0; i < 8000 && req_ready !== 1'b1; i++) @(negedge clk);
		if (i == 8000) begin
			num_errors++;
			$display("mismatch at %0t: init timeout", $time);
			give_verdict();
		end
		chk(n_rf, 64, "init refreshes");
		chk(n_ce, 8, "init enables");
		chk(row_w, 7'h40, "init row");
		$display("test init done");
		for (i = 0; i < 16; i++) begin
			aa[i] = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($random(seed));
			wd = 8'($random(seed));
			run(i[0] ? lpsr_pkg::LPSR_OP_LATE_WRITE : lpsr_pkg::LPSR_OP_EARLY_WRITE, aa[i], wd);
			exp_mem[aa[i]] = wd;
		end
		for (i = 0; i < 16; i++) begin
			run(lpsr_pkg::LPSR_OP_READ, aa[i], 8'h00);
			chk(rdat, exp_mem[aa[i]], "readback");
		end
		// A stretched enable still returns the stored byte
		run(lpsr_pkg::LPSR_OP_READ, aa[5], 8'h00, 32'h0000_0014);
		chk(rdat, exp_mem[aa[5]], "long enable read");
		$display("test write read done");
		nce0 = n_ce;
		run(lpsr_pkg::LPSR_OP_DESELECT, aa[2], ~8'(exp_mem[aa[2]]));
		run(lpsr_pkg::LPSR_OP_EXT_REFRESH, aa[2], 8'h00);
		chk(n_ce, nce0 + 2, "enable count");
		run(lpsr_pkg::LPSR_OP_READ, aa[2], 8'h00);
		chk(rdat, exp_mem[aa[2]], "deselect kept");
		$display("test standby done");
		base = row_w;
		repeat (70) run(lpsr_pkg::LPSR_OP_PULSE_REFRESH, 13'h0000, 8'h00);
		chk(row_w, 7'(base + 7'h46), "row wrap");
		run(lpsr_pkg::LPSR_OP_SELF_REFRESH, 13'h0000, 8'h00);
		chk(self_ns >= SELF * 50.0, 1, "self low time");
		run(lpsr_pkg::LPSR_OP_READ, aa[3], 8'h00);
		chk(rdat, exp_mem[aa[3]], "after self");
		// A longer hold keeps the strobe low past the minimum
		run(lpsr_pkg::LPSR_OP_SELF_REFRESH, 13'h0000, 8'h00, 32'h0000_001e);
		chk(self_ns >= 30 * 50.0, 1, "held self low time");
		run(lpsr_pkg::LPSR_OP_READ, aa[4], 8'h00);
		chk(rdat, exp_mem[aa[4]], "after held self");
		chk(n_viol, 0, "host timing");
		$display("test refresh done");
		give_verdict();
	end
endmodule
`default_nettype wire
